// ==== design/brc_regs.sv ====
// buck rail configuration registers with shutdown sequencing
// How it works
// - rail a soft-start time from ramp bits 7:6, 4/2/1/0.5 ms.
// - rail a shutdown period from ramp bits 5:4, 4/2/1/0.5 ms.
// - shutdown period applies only for shutdown option codes 00, 01, 10.
// - after chip enable falls, count starts when last rail is off.
// - period expiry moves state machine to standby, then reset.
// - ramp-up slew from ramp bits 3:2, 2/4/8/16 mV/us.
// - ramp-down slew from ramp bits 1:0, 2/4/8/16 mV/us.
// - phase offset 0/90/180/270 deg from config bits 6:5 when sync on.
// - switching frequency from config bits 4:2, eight codes.
// - discharge strength from config bits 1:0: off, slow, medium, fast.
// - rail b phase sync enabled by enable bit 4.
// - rail b spread spectrum in pulse-frequency mode by enable bit 3.
// - rail b ultrasonic mode by enable bit 2.
// - rail b kept on in sleep by enable bit 1.
// - rail b kept on in active by enable bit 0.
`timescale 1ns/1ps
`default_nettype none
module brc_regs
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata_r,
    input  wire logic       chip_enable_input,
    input  wire logic       rails_all_off,
    input  wire logic [1:0] shutdown_option,
    input  wire logic       sleep_state,
    output var  logic [1:0] rail_a_soft_start_time,
    output var  logic [1:0] rail_a_shutdown_period,
    output var  logic [1:0] rail_a_ramp_up_rate,
    output var  logic [1:0] rail_a_ramp_down_rate,
    output var  logic [1:0] rail_a_phase_offset,
    output var  logic [2:0] rail_a_switch_frequency,
    output var  logic [1:0] rail_a_discharge_strength,
    output var  logic       rail_b_phase_sync_on,
    output var  logic       rail_b_spread_spectrum_on,
    output var  logic       rail_b_ultrasonic_on,
    output var  logic       rail_b_on_in_sleep,
    output var  logic       rail_b_on_in_active,
    output var  logic       rail_b_run_r,
    output var  logic       pwr_standby_r,
    output var  logic       pwr_reset_req_r
);
    logic [7:0] rail_a_ramp_timing_r;
    logic [7:0] rail_a_switching_config_r;
    logic [7:0] rail_b_enable_flags_r;
    logic       chip_en_s;
    logic       rails_off_s;
    logic       sleep_s;

    brc_sync u_sync_en
    (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .din     (chip_enable_input),
        .dout    (chip_en_s)
    );

    brc_sync u_sync_off
    (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .din     (rails_all_off),
        .dout    (rails_off_s)
    );

    brc_sync u_sync_slp
    (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .din     (sleep_state),
        .dout    (sleep_s)
    );

    // register writes; masks drop unused bits
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rail_a_ramp_timing_r      <= brc_pkg::RST_RAMP;
            rail_a_switching_config_r <= brc_pkg::RST_SWCFG;
            rail_b_enable_flags_r     <= brc_pkg::RST_ENABLE;
        end
        else if (ce && reg_wr)
        begin
            unique case (reg_addr)
                brc_pkg::ADDR_RAMP:
                    rail_a_ramp_timing_r      <= reg_wdata & brc_pkg::MASK_RAMP;
                brc_pkg::ADDR_SWCFG:
                    rail_a_switching_config_r <= reg_wdata & brc_pkg::MASK_SWCFG;
                brc_pkg::ADDR_ENABLE:
                    rail_b_enable_flags_r     <= reg_wdata & brc_pkg::MASK_ENABLE;
                default:
                    ;
            endcase
        end
    end

    // register reads; unmapped index returns zero
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata_r <= 8'h00;
        else if (ce && reg_rd)
        begin
            unique case (reg_addr)
                brc_pkg::ADDR_RAMP:   reg_rdata_r <= rail_a_ramp_timing_r;
                brc_pkg::ADDR_SWCFG:  reg_rdata_r <= rail_a_switching_config_r;
                brc_pkg::ADDR_ENABLE: reg_rdata_r <= rail_b_enable_flags_r;
                default:              reg_rdata_r <= 8'h00;
            endcase
        end
    end

    // field decode: outputs are register bits directly
    always_comb
    begin
        rail_a_soft_start_time    = rail_a_ramp_timing_r[brc_pkg::SOFT_LSB +: 2];
        rail_a_shutdown_period    = rail_a_ramp_timing_r[brc_pkg::SHUT_LSB +: 2];
        rail_a_ramp_up_rate       = rail_a_ramp_timing_r[brc_pkg::UP_LSB +: 2];
        rail_a_ramp_down_rate     = rail_a_ramp_timing_r[brc_pkg::DN_LSB +: 2];
        rail_a_phase_offset       = rail_a_switching_config_r[brc_pkg::PHASE_LSB +: 2];
        rail_a_switch_frequency   = rail_a_switching_config_r[brc_pkg::FREQ_LSB +: 3];
        rail_a_discharge_strength = rail_a_switching_config_r[brc_pkg::DIS_LSB +: 2];
        rail_b_phase_sync_on      = rail_b_enable_flags_r[brc_pkg::EN_SYNC];
        rail_b_spread_spectrum_on = rail_b_enable_flags_r[brc_pkg::EN_SS];
        rail_b_ultrasonic_on      = rail_b_enable_flags_r[brc_pkg::EN_ULTRA];
        rail_b_on_in_sleep        = rail_b_enable_flags_r[brc_pkg::EN_SLEEP];
        rail_b_on_in_active       = rail_b_enable_flags_r[brc_pkg::EN_ACTIVE];
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            rail_b_run_r <= 1'b0;
        else if (ce)
            rail_b_run_r <= chip_en_s &&
                (sleep_s ? rail_b_enable_flags_r[brc_pkg::EN_SLEEP]
                         : rail_b_enable_flags_r[brc_pkg::EN_ACTIVE]);
    end

    brc_shutdown u_shut
    (
        .mclk          (mclk),
        .sys_rst       (sys_rst),
        .ce            (ce),
        .chip_en       (chip_en_s),
        .rails_all_off (rails_off_s),
        .shut_code     (rail_a_ramp_timing_r[brc_pkg::SHUT_LSB +: 2]),
        .shut_option   (shutdown_option),
        .standby_r     (pwr_standby_r),
        .reset_req_r   (pwr_reset_req_r)
    );
endmodule // brc_regs
`default_nettype wire

// ==== design/brc_pkg.sv ====
// shared constants for the buck rail configuration register bank
package brc_pkg;
    // register indices, chosen within the local bank
    localparam logic [1:0] ADDR_RAMP   = 2'h0;
    localparam logic [1:0] ADDR_SWCFG  = 2'h1;
    localparam logic [1:0] ADDR_ENABLE = 2'h2;
    // reset values
    localparam logic [7:0] RST_RAMP   = 8'h00;
    localparam logic [7:0] RST_SWCFG  = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    // field positions, ramp/timing register
    localparam int SOFT_LSB  = 6;
    localparam int SHUT_LSB  = 4;
    localparam int UP_LSB    = 2;
    localparam int DN_LSB    = 0;
    // field positions, switching config register
    localparam int PHASE_LSB = 5;
    localparam int FREQ_LSB  = 2;
    localparam int DIS_LSB   = 0;
    // field positions, enable register
    localparam int EN_SYNC   = 4;
    localparam int EN_SS     = 3;
    localparam int EN_ULTRA  = 2;
    localparam int EN_SLEEP  = 1;
    localparam int EN_ACTIVE = 0;
    // writable masks: unused bits stay zero
    localparam logic [7:0] MASK_RAMP   = 8'hff;
    localparam logic [7:0] MASK_SWCFG  = 8'h7f;
    localparam logic [7:0] MASK_ENABLE = 8'h1f;
    // shutdown period in microseconds per code, and cycles at mclk
    localparam int CLK_MHZ      = 10;
    localparam int SHUT_US_C0   = 4000;
    localparam int SHUT_US_C1   = 2000;
    localparam int SHUT_US_C2   = 1000;
    localparam int SHUT_US_C3   = 500;
    localparam int SHUT_CYC_C0  = SHUT_US_C0 * CLK_MHZ;
    localparam int SHUT_CYC_C1  = SHUT_US_C1 * CLK_MHZ;
    localparam int SHUT_CYC_C2  = SHUT_US_C2 * CLK_MHZ;
    localparam int SHUT_CYC_C3  = SHUT_US_C3 * CLK_MHZ;
    localparam int CNT_W        = 16;
    // shutdown option code that bypasses the timed period
    localparam logic [1:0] SHUT_OPT_NONE = 2'b11;
    typedef enum logic [1:0] {
        PS_ON,
        PS_WAIT_OFF,
        PS_COUNT,
        PS_STANDBY
    } brc_pstate_type;
endpackage

// ==== design/brc_sync.sv ====
// two-flop synchroniser for a pin-level input
`timescale 1ns/1ps
`default_nettype none
module brc_sync
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic din,
    output var  logic dout
);
    logic meta_r;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end
        else if (ce)
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // brc_sync
`default_nettype wire

// ==== design/brc_shutdown.sv ====
// shutdown period timer and power state sequencing
`timescale 1ns/1ps
`default_nettype none
module brc_shutdown
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       chip_en,
    input  wire logic       rails_all_off,
    input  wire logic [1:0] shut_code,
    input  wire logic [1:0] shut_option,
    output var  logic       standby_r,
    output var  logic       reset_req_r
);
    brc_pkg::brc_pstate_type state_r;
    logic [brc_pkg::CNT_W-1:0] cnt_r;
    logic                      chip_en_d_r;
    logic [brc_pkg::CNT_W-1:0] load_val;
    logic                      timed;

    always_comb
    begin
        unique case (shut_code)
            2'h0: load_val = brc_pkg::CNT_W'(brc_pkg::SHUT_CYC_C0 - 1);
            2'h1: load_val = brc_pkg::CNT_W'(brc_pkg::SHUT_CYC_C1 - 1);
            2'h2: load_val = brc_pkg::CNT_W'(brc_pkg::SHUT_CYC_C2 - 1);
            2'h3: load_val = brc_pkg::CNT_W'(brc_pkg::SHUT_CYC_C3 - 1);
        endcase
    end

    assign timed = (shut_option != brc_pkg::SHUT_OPT_NONE);

    // resets low like the synchroniser, so release never shows a false falling edge
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            chip_en_d_r <= 1'b0;
        else if (ce)
            chip_en_d_r <= chip_en;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r     <= brc_pkg::PS_ON;
            cnt_r       <= '0;
            standby_r   <= 1'b0;
            reset_req_r <= 1'b0;
        end
        else if (ce)
        begin
            reset_req_r <= 1'b0;
            unique case (state_r)
                brc_pkg::PS_ON:
                begin
                    standby_r <= 1'b0;
                    if (chip_en_d_r && !chip_en)
                        state_r <= brc_pkg::PS_WAIT_OFF;
                end
                brc_pkg::PS_WAIT_OFF:
                begin
                    if (rails_all_off && timed)
                    begin
                        cnt_r   <= load_val;
                        state_r <= brc_pkg::PS_COUNT;
                    end
                    else if (rails_all_off)
                        state_r <= brc_pkg::PS_ON;
                end
                brc_pkg::PS_COUNT:
                begin
                    if (cnt_r == '0)
                    begin
                        standby_r <= 1'b1;
                        state_r   <= brc_pkg::PS_STANDBY;
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                brc_pkg::PS_STANDBY:
                begin
                    reset_req_r <= 1'b1;
                    standby_r   <= 1'b0;
                    state_r     <= brc_pkg::PS_ON;
                end
            endcase
        end
    end
endmodule // brc_shutdown
`default_nettype wire

// ==== verif/brc_power_model.sv ====
// rail sequencer model: reports last rail off a while after chip enable drops
`timescale 1ns/1ps
`default_nettype none
module brc_power_model
(
    input  wire logic mclk,
    input  wire logic chip_enable_input,
    output var  logic rails_all_off
);
    logic [3:0] dly_r;
    // rails go down in turn, so last-off lags the enable
    always_ff @(posedge mclk)
    begin
        if (chip_enable_input)
            dly_r <= 4'h0;
        else if (dly_r != 4'hf)
            dly_r <= dly_r + 4'h1;
    end
    assign rails_all_off = (dly_r == 4'hf);
endmodule // brc_power_model
`default_nettype wire

// ==== verif/brc_regs_monitor.sv ====
// concurrent checks on the rail configuration register ports
`timescale 1ns/1ps
`default_nettype none
module brc_regs_monitor
(
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       ce,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    input wire logic [1:0] shutdown_option,
    input wire logic [7:0] ramp_f,
    input wire logic [6:0] cfg_f,
    input wire logic [4:0] flag_f,
    input wire logic       pwr_standby_r,
    input wire logic       pwr_reset_req_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_ramp_write: assert property (ce && reg_wr && reg_addr == 2'h0 |=> ramp_f == $past(reg_wdata))
        else $error("ramp fields differ from write");
    a_cfg_write: assert property (ce && reg_wr && reg_addr == 2'h1 |=> cfg_f == $past(reg_wdata[6:0]))
        else $error("config fields differ from write");
    a_flag_write: assert property (ce && reg_wr && reg_addr == 2'h2 |=> flag_f == $past(reg_wdata[4:0]))
        else $error("enable flags differ from write");
    a_fields_hold: assert property (!(ce && reg_wr) |=> $stable({ramp_f, cfg_f, flag_f}))
        else $error("fields changed without write");
    a_unmapped_zero: assert property (ce && reg_rd && reg_addr == 2'h3 |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    a_unused_bits: assert property (ce && reg_rd && reg_addr[1] != reg_addr[0] |=> reg_rdata_r[7] == 1'b0)
        else $error("unused bit reads one");
    a_standby_reset: assert property (pwr_standby_r |=> pwr_reset_req_r ##1 !pwr_reset_req_r)
        else $error("reset pulse not after standby");
    a_standby_single: assert property (pwr_standby_r |=> !pwr_standby_r [*3])
        else $error("standby pulse too long");
    a_reset_cause: assert property ($rose(pwr_reset_req_r) |-> $past(pwr_standby_r))
        else $error("reset pulse without standby");
    a_option_bypass: assert property (pwr_standby_r |-> $past(shutdown_option, 8) != 2'b11)
        else $error("standby with bypass option");
    c_write: cover property (ce && reg_wr && reg_addr == 2'h2);
    c_unmapped: cover property (ce && reg_rd && reg_addr == 2'h3);
    c_standby: cover property (pwr_standby_r ##1 pwr_reset_req_r);
endmodule // brc_regs_monitor
bind brc_regs brc_regs_monitor brc_regs_monitor_inst (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .shutdown_option(shutdown_option), .pwr_standby_r(pwr_standby_r), .pwr_reset_req_r(pwr_reset_req_r),
    .ramp_f({rail_a_soft_start_time, rail_a_shutdown_period, rail_a_ramp_up_rate, rail_a_ramp_down_rate}),
    .cfg_f({rail_a_phase_offset, rail_a_switch_frequency, rail_a_discharge_strength}),
    .flag_f({rail_b_phase_sync_on, rail_b_spread_spectrum_on, rail_b_ultrasonic_on, rail_b_on_in_sleep,
    rail_b_on_in_active}));
`default_nettype wire

// ==== verif/tb_brc_regs.sv ====
// self-checking bench for the rail configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_brc_regs;
    logic       mclk = 1'b0, sys_rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       chip_enable_input = 1'b1, sleep_state = 1'b0, rails_all_off;
    logic [1:0] reg_addr = 2'h0, shutdown_option = 2'h0, sst, shp, upr, dnr, pho, dis;
    logic [2:0] frq;
    logic [7:0] reg_wdata = 8'h00, reg_rdata_r, d;
    logic       psy, ssp, ult, slp, act, run, stby, rstq;
    int         err_count = 0, n_compared = 0, n_standby = 0, cyc = 0, n, p;
    always #50 mclk = ~mclk;
    brc_regs brc_regs_inst (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .chip_enable_input(chip_enable_input), .rails_all_off(rails_all_off), .shutdown_option(shutdown_option),
        .sleep_state(sleep_state), .rail_a_soft_start_time(sst), .rail_a_shutdown_period(shp),
        .rail_a_ramp_up_rate(upr), .rail_a_ramp_down_rate(dnr), .rail_a_phase_offset(pho),
        .rail_a_switch_frequency(frq), .rail_a_discharge_strength(dis), .rail_b_phase_sync_on(psy),
        .rail_b_spread_spectrum_on(ssp), .rail_b_ultrasonic_on(ult), .rail_b_on_in_sleep(slp),
        .rail_b_on_in_active(act), .rail_b_run_r(run), .pwr_standby_r(stby), .pwr_reset_req_r(rstq));
    brc_power_model brc_power_model_inst (.mclk(mclk), .chip_enable_input(chip_enable_input),
        .rails_all_off(rails_all_off));
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        #1;
        chk("read data", reg_rdata_r, exp);
    endtask
    // a hang costs a mismatch, not a stuck run
    // pulses counted away from the edge that launches them, so no race
    always @(negedge mclk)
        n_standby += (stby === 1'b1);
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            err_count++;
            close_out();
        end
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rdc(2'h0, brc_pkg::RST_RAMP);
        rdc(2'h1, brc_pkg::RST_SWCFG);
        rdc(2'h2, brc_pkg::RST_ENABLE);
        $display("test reset values done");
        for (int i = 0; i < 32; i++)
        begin
            d = {4{i[1:0]}};
            wr(2'h0, d);
            chk("ramp fields", {sst, shp, upr, dnr}, d);
            rdc(2'h0, d);
            d = {1'b1, i[1:0], i[2:0], ~i[1:0]};
            wr(2'h1, d);
            chk("config fields", {1'b0, pho, frq, dis}, d & brc_pkg::MASK_SWCFG);
            rdc(2'h1, d & brc_pkg::MASK_SWCFG);
            d = {3'b111, i[4:0]};
            wr(2'h2, d);
            chk("enable flags", {3'b000, psy, ssp, ult, slp, act}, d & brc_pkg::MASK_ENABLE);
            rdc(2'h2, d & brc_pkg::MASK_ENABLE);
        end
        $display("test field codes done");
        wr(2'h3, 8'hff);
        rdc(2'h3, 8'h00);
        rdc(2'h2, 8'h1f);
        rdc(2'h0, 8'hff);
        rdc(2'h1, 8'h7c);
        @(posedge mclk);
        ce <= 1'b0;
        wr(2'h2, 8'h00);
        @(posedge mclk);
        ce <= 1'b1;
        rdc(2'h2, 8'h1f);
        $display("test unmapped and freeze done");
        wr(2'h2, 8'h01);
        repeat (6) @(posedge mclk);
        #1 chk("run active", {7'h0, run}, 8'h01);
        @(posedge mclk);
        sleep_state <= 1'b1;
        repeat (6) @(posedge mclk);
        #1 chk("run sleep off", {7'h0, run}, 8'h00);
        wr(2'h2, 8'h02);
        repeat (6) @(posedge mclk);
        #1 chk("run sleep on", {7'h0, run}, 8'h01);
        $display("test rail b run done");
        wr(2'h0, 8'h30);
        @(posedge mclk);
        shutdown_option <= 2'b11;
        chip_enable_input <= 1'b0;
        repeat (6000) @(posedge mclk);
        chip_enable_input <= 1'b1;
        repeat (40) @(posedge mclk);
        #1 chk("bypass pulses", 8'(n_standby), 8'h00);
        for (int j = 0; j < 4; j++)
        begin
            wr(2'h0, 8'(j << brc_pkg::SHUT_LSB));
            @(posedge mclk);
            shutdown_option <= 2'(j % 3);
            chip_enable_input <= 1'b0;
            // period is timed from the last rail off
            while (rails_all_off !== 1'b1)
            begin
                @(posedge mclk);
                #1;
            end
            n = 0;
            while (stby !== 1'b1)
            begin
                @(posedge mclk);
                #1;
                n++;
            end
            p = (j == 0) ? brc_pkg::SHUT_CYC_C0 : (j == 1) ? brc_pkg::SHUT_CYC_C1
                : (j == 2) ? brc_pkg::SHUT_CYC_C2 : brc_pkg::SHUT_CYC_C3;
            chk("period window", 8'(n >= p && n <= p + 10), 8'h01);
            @(posedge mclk);
            #1 chk("reset after standby", {7'h0, rstq}, 8'h01);
            chk("run chip off", {7'h0, run}, 8'h00);
            @(posedge mclk);
            chip_enable_input <= 1'b1;
            repeat (20) @(posedge mclk);
        end
        $display("test shutdown done");
        close_out();
    end
endmodule // tb_brc_regs
`default_nettype wire
